// ==== rtl/cbc_pkg.sv ====
// package for the counter board control word block
// assumes a 32-bit apb slave and one 100 MHz clock
package cbc_pkg;
    // ********************************************
    // register map (printed offsets are indexes)
    // ********************************************
    localparam logic [7:0]  CBC_IDX_CTRL      = 8'h05;  // reset/compare/stop word
    localparam logic [7:0]  CBC_IDX_FORCE     = 8'h06;  // output force word
    localparam logic [7:0]  CBC_IDX_MODE      = 8'h07;  // reset method per counter
    localparam logic [7:0]  CBC_IDX_STATUS    = 8'h08;  // block state, read only
    localparam logic [7:0]  CBC_IDX_COUNT0    = 8'h09;  // first of four count values, read only
    localparam logic [11:0] CBC_ADDR_CTRL     = 12'h014;
    localparam logic [11:0] CBC_ADDR_FORCE    = 12'h018;
    localparam logic [11:0] CBC_ADDR_MODE     = 12'h01c;
    localparam logic [11:0] CBC_ADDR_STATUS   = 12'h020;
    localparam logic [11:0] CBC_ADDR_COUNT0   = 12'h024;
    // ********************************************
    // field positions
    // ********************************************
    localparam int          CBC_RST_LSB       = 0;
    localparam int          CBC_CMP_LSB       = 8;
    localparam int          CBC_STOP_LSB      = 12;
    localparam int          CBC_FORCE_LSB     = 0;
    localparam int          CBC_FORCE_EN_BIT  = 4;
    localparam int          CBC_NCNT          = 4;
    // ********************************************
    // reset values and write masks
    // ********************************************
    localparam logic [15:0] CBC_CTRL_RST      = 16'h0000;
    localparam logic [15:0] CBC_FORCE_RST     = 16'h0000;
    localparam logic [3:0]  CBC_MODE_RST      = 4'h0;
    localparam logic [15:0] CBC_CTRL_MASK     = 16'hff0f;
    localparam logic [15:0] CBC_FORCE_MASK    = 16'h001f;
    // scan period in clock cycles
    localparam int          CBC_SCAN_CYCLES   = 16;
endpackage : cbc_pkg

// ==== rtl/cbc_counter.sv ====
// one counter channel: count, reset, compare enable, stop
// assumes count pulse and index pulse already synchronised
`timescale 1ns/100ps
module cbc_counter
    import cbc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             count_pulse,
    input  wire logic             index_pulse,
    input  wire logic             index_mode,
    input  wire logic             rst_bit,
    input  wire logic             rst_rise,
    input  wire logic             cmp_rise,
    input  wire logic             cmp_fall,
    input  wire logic             stop_bit,
    output logic [WIDTH-1:0]      count_value,
    output logic                  comparing
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             cmp;
    } cbc_chan_t;
    cbc_chan_t st_reg, st_next;

    // counting, resets and comparison state
    always_comb begin
        st_next = st_reg;
        if (!stop_bit && count_pulse) begin // R5
            st_next.cnt = st_reg.cnt + 1'b1;
        end
        if (index_mode && rst_bit && index_pulse) begin // R1
            st_next.cnt = '0;
        end
        if (!index_mode && rst_rise) begin // R2
            st_next.cnt = '0;
        end
        if (cmp_rise) begin // R3
            st_next.cmp = 1'b1;
        end else if (cmp_fall) begin // R4
            st_next.cmp = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_value = st_reg.cnt;
    assign comparing   = st_reg.cmp;
endmodule : cbc_counter

// ==== rtl/cbc_top.sv ====
// counter board control words behind an apb slave
// What this block does
// R1 - reset bits 0..3 enable index-pulse reset in combined mode
// R2 - in software-only mode a rising reset bit clears the counter
// R3 - rising compare bit 8..11 starts range comparison
// R4 - falling compare bit stops comparison until next rise
// R5 - stop bits 12..15 at 1 halt counting, 0 lets it run
// R6 - force bits 0..3 of second word drive outputs on
// R7 - force enable bit 4 gates all four force bits
// R8 - global output-off holds all four outputs off
// R9 - both words sampled once per scan, edges seen between scans
// R10 - per-counter reset method set in a separate mode register
// assumes apb master, pins arrive asynchronous to clock
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module cbc_top
    import cbc_pkg::*;
#(
    parameter int WIDTH      = 16,
    parameter int SCAN_LEN   = CBC_SCAN_CYCLES
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [3:0]   count_in,
    input  wire logic [3:0]   index_in,
    input  wire logic [3:0]   ext_out_req,
    input  wire logic         output_off,
    output logic [3:0]        ext_out,
    output logic [3:0]        comparing
);
    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] force_w;
        logic [3:0]  mode;
        logic [15:0] ctrl_snap;
        logic [15:0] ctrl_prev;
        logic [15:0] force_snap;
        logic [7:0]  scan_cnt;
        logic        scan_tick;
        logic [3:0]  cnt_s1, cnt_s2, cnt_s3;
        logic [3:0]  idx_s1, idx_s2, idx_s3;
        logic [1:0]  off_s;
        logic        off_s3;
        logic [3:0]  cnt_lvl;
        logic [3:0]  idx_lvl;
        logic        off_lvl;
        logic [3:0]  out;
        logic [3:0]  cmp;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } cbc_state_t;
    cbc_state_t st_reg, st_next;

    logic [WIDTH-1:0] cnt_val [CBC_NCNT];
    logic [3:0]       cmp_w;
    logic [3:0]       cnt_pulse;
    logic [3:0]       idx_pulse;
    logic [3:0]       rst_rise, cmp_rise, cmp_fall;
    logic             setup;

    // decode a byte address to one of the four count value words
    function automatic logic cbc_count_hit(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - CBC_ADDR_COUNT0;
        return (a >= CBC_ADDR_COUNT0) && (rel < 12'h010) && (rel[1:0] == 2'b00);
    endfunction : cbc_count_hit

    // decode a byte address to a mapped flag
    function automatic logic cbc_mapped(input logic [11:0] a);
        return (a == CBC_ADDR_CTRL) || (a == CBC_ADDR_FORCE) ||
               (a == CBC_ADDR_MODE) || (a == CBC_ADDR_STATUS) ||
               cbc_count_hit(a);
    endfunction : cbc_mapped

    // settled level: follows stages 2 and 3 only where they agree
    function automatic logic [3:0] cbc_settle(input logic [3:0] s2,
                                              input logic [3:0] s3,
                                              input logic [3:0] lvl);
        return (s2 & s3) | (lvl & (s2 | s3));
    endfunction : cbc_settle

    // ********************************************
    // pin edges: change counts once stages 2 and 3 agree
    // ********************************************
    // a rise counts once, when both stages are high and the settled level is low
    assign cnt_pulse = st_reg.cnt_s2 & st_reg.cnt_s3 & ~st_reg.cnt_lvl;
    assign idx_pulse = st_reg.idx_s2 & st_reg.idx_s3 & ~st_reg.idx_lvl;

    // edges between two consecutive scan snapshots
    assign rst_rise = st_reg.scan_tick ? (st_reg.ctrl_snap[CBC_RST_LSB +: 4]
                      & ~st_reg.ctrl_prev[CBC_RST_LSB +: 4]) : 4'h0;   // R9
    assign cmp_rise = st_reg.scan_tick ? (st_reg.ctrl_snap[CBC_CMP_LSB +: 4]
                      & ~st_reg.ctrl_prev[CBC_CMP_LSB +: 4]) : 4'h0;   // R9
    assign cmp_fall = st_reg.scan_tick ? (~st_reg.ctrl_snap[CBC_CMP_LSB +: 4]
                      & st_reg.ctrl_prev[CBC_CMP_LSB +: 4]) : 4'h0;    // R9

    // ********************************************
    // counter channels
    // ********************************************
    for (genvar i = 0; i < CBC_NCNT; i++) begin : g_chan
        cbc_counter #(
            .WIDTH (WIDTH)
        ) u_chan (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .count_pulse (cnt_pulse[i]),
            .index_pulse (idx_pulse[i]),
            .index_mode  (st_reg.mode[i]),
            .rst_bit     (st_reg.ctrl_snap[CBC_RST_LSB + i]),
            .rst_rise    (rst_rise[i]),
            .cmp_rise    (cmp_rise[i]),
            .cmp_fall    (cmp_fall[i]),
            .stop_bit    (st_reg.ctrl_snap[CBC_STOP_LSB + i]),
            .count_value (cnt_val[i]),
            .comparing   (cmp_w[i])
        );
    end

    assign setup = psel && !penable;

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        logic [3:0]  frc;
        logic [11:0] coff;
        frc = 4'h0;
        coff = paddr - CBC_ADDR_COUNT0;   // offset into the count value words
        st_next = st_reg;
        // synchronisers, first stage read only by second
        st_next.cnt_s1 = count_in;
        st_next.cnt_s2 = st_reg.cnt_s1;
        st_next.cnt_s3 = st_reg.cnt_s2;
        st_next.idx_s1 = index_in;
        st_next.idx_s2 = st_reg.idx_s1;
        st_next.idx_s3 = st_reg.idx_s2;
        st_next.off_s  = {st_reg.off_s[0], output_off};
        st_next.off_s3 = st_reg.off_s[1];
        // settled levels: a one-cycle disagreement never counts as a change
        st_next.cnt_lvl = cbc_settle(st_reg.cnt_s2, st_reg.cnt_s3, st_reg.cnt_lvl);
        st_next.idx_lvl = cbc_settle(st_reg.idx_s2, st_reg.idx_s3, st_reg.idx_lvl);
        if (st_reg.off_s[1] == st_reg.off_s3) begin
            st_next.off_lvl = st_reg.off_s3;
        end
        // scan divider, one-cycle tick
        st_next.scan_tick = 1'b0;
        if (st_reg.scan_cnt == 8'(SCAN_LEN - 1)) begin
            st_next.scan_cnt  = 8'h00;
            st_next.scan_tick = 1'b1;
        end else begin
            st_next.scan_cnt = st_reg.scan_cnt + 8'h01;
        end
        // refresh both words once per scan
        if (st_reg.scan_tick) begin // R9
            st_next.ctrl_prev = st_reg.ctrl_snap;
        end
        if (st_next.scan_tick) begin // R9
            st_next.ctrl_snap  = st_reg.ctrl;
            st_next.force_snap = st_reg.force_w;
        end
        // external outputs: off overrides forcing
        if (st_reg.force_snap[CBC_FORCE_EN_BIT]) begin // R7
            frc = st_reg.force_snap[CBC_FORCE_LSB +: 4]; // R6
        end
        if (st_next.off_lvl) begin
            st_next.out = 4'h0; // R8
        end else begin
            st_next.out = ext_out_req | frc; // R6
        end
        st_next.cmp = cmp_w;
        // apb slave, no wait state: answer in first access cycle
        st_next.ready  = 1'b0;
        st_next.slverr = 1'b0;
        if (setup) begin
            st_next.ready  = 1'b1;
            st_next.slverr = !cbc_mapped(paddr);
            st_next.rdata  = 32'h0;
            case (paddr)
                CBC_ADDR_CTRL:   st_next.rdata = {16'h0, st_reg.ctrl};
                CBC_ADDR_FORCE:  st_next.rdata = {16'h0, st_reg.force_w};
                CBC_ADDR_MODE:   st_next.rdata = {28'h0, st_reg.mode};
                CBC_ADDR_STATUS: st_next.rdata = {24'h0, st_reg.out, st_reg.cmp};
                default: begin
                    // count values, read only, zero above the counter width
                    if (cbc_count_hit(paddr)) begin
                        st_next.rdata = 32'(cnt_val[coff[3:2]]);
                    end
                end
            endcase
        end
        if (psel && penable && st_reg.ready && pwrite) begin
            case (paddr)
                CBC_ADDR_CTRL:  st_next.ctrl    = pwdata[15:0] & CBC_CTRL_MASK;
                CBC_ADDR_FORCE: st_next.force_w = pwdata[15:0] & CBC_FORCE_MASK;
                CBC_ADDR_MODE:  st_next.mode    = pwdata[3:0]; // R10
                default:        st_next.mode    = st_reg.mode;
            endcase
        end
    end

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg         <= '0;
            st_reg.ctrl    <= CBC_CTRL_RST;
            st_reg.force_w <= CBC_FORCE_RST;
            st_reg.mode    <= CBC_MODE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata    = st_reg.rdata;
    assign pready    = st_reg.ready;
    assign pslverr   = st_reg.slverr;
    assign ext_out   = st_reg.out;
    assign comparing = st_reg.cmp;
endmodule : cbc_top

// ==== tb/cbc_chk.sv ====
// checker for the counter board control word block
// assumes it is bound to cbc_top and sees only its ports
`timescale 1ns/100ps
module cbc_chk
    import cbc_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  count_in,
    input wire logic [3:0]  index_in,
    input wire logic [3:0]  ext_out_req,
    input wire logic        output_off,
    input wire logic [3:0]  ext_out,
    input wire logic [3:0]  comparing
);
    // ********************************************
    // bus and output properties
    // ********************************************
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // setup phase and a held global off
    sequence setup_s; psel && !penable; endsequence
    sequence off_s; output_off [*6]; endsequence
    chk_ready_after: assert property (setup_s |=> pready) else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    chk_ready_sel: assert property (pready |-> psel && penable) else $error("ready unselected");
    chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_off_holds: assert property (off_s |-> ext_out == 4'h0) else $error("output on");
    chk_req_passes: assert property ((!output_off) [*6] |=>
        (ext_out & $past(ext_out_req)) == $past(ext_out_req)) else $error("request lost");
    chk_status_read: assert property (pready && !pwrite && paddr == CBC_ADDR_STATUS |->
        prdata[7:0] == {$past(ext_out), $past(comparing)}) else $error("status wrong");
    chk_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
        ext_out == 4'h0 && comparing == 4'h0 && !pready) else $error("reset left state");
endmodule : cbc_chk

// ==== tb/testbench.sv ====
// self-checking bench for the counter board control word block
// assumes cbc_top with a short scan and the checker bound below
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import cbc_pkg::*;
    localparam int SL = 4;
    localparam int WT = 2 * SL + 8;
    logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, output_off, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  count_in, index_in, ext_out_req, ext_out, comparing;
    int          n_mismatch, tests_run;
    // ********************************************
    // design and clock
    // ********************************************
    cbc_top #(.SCAN_LEN(SL)) dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_in(count_in),
        .index_in(index_in), .ext_out_req(ext_out_req), .output_off(output_off),
        .ext_out(ext_out), .comparing(comparing));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // one apb transfer, held until ready is sampled; the watchdog ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);   // idle edge, so a next call never drives psel twice at once
    endtask : apb
    // ********************************************
    // scenarios
    // ********************************************
    task t_regs;
        apb(0, CBC_ADDR_CTRL, 0);
        `CHK(rd, 32'h0)
        apb(1, CBC_ADDR_CTRL, 32'hffff_ffff);
        apb(0, CBC_ADDR_CTRL, 0);
        `CHK(rd, 32'h0000_ff0f)
        apb(1, CBC_ADDR_FORCE, 32'hffff_ffff);
        apb(0, CBC_ADDR_FORCE, 0);
        `CHK(rd, 32'h0000_001f)
        apb(1, CBC_ADDR_MODE, 32'h0000_000f);
        apb(0, CBC_ADDR_MODE, 0);
        `CHK(rd[3:0], 4'hf)
        apb(0, 12'h100, 0);
        `CHK({er, rd}, 33'h1_0000_0000)
        apb(1, CBC_ADDR_CTRL, 0);
        apb(1, CBC_ADDR_FORCE, 0);
        $display("test regs done");
    endtask : t_regs
    task t_cmp;
        apb(1, CBC_ADDR_CTRL, 32'h0000_f50f);
        repeat (WT) @(posedge clock);
        `CHK(comparing, 4'h5)
        apb(0, CBC_ADDR_STATUS, 0);
        `CHK(rd[3:0], 4'h5)
        apb(1, CBC_ADDR_CTRL, 32'h0000_0100);
        repeat (WT) @(posedge clock);
        `CHK(comparing, 4'h1)
        apb(1, CBC_ADDR_CTRL, 32'h0000_0000);
        repeat (WT) @(posedge clock);
        `CHK(comparing, 4'h0)
        $display("test compare done");
    endtask : t_cmp
    task t_force;
        apb(1, CBC_ADDR_FORCE, 32'h0000_000f);
        repeat (WT) @(posedge clock);
        `CHK(ext_out, 4'h0)
        apb(1, CBC_ADDR_FORCE, 32'h0000_0015);
        repeat (WT) @(posedge clock);
        `CHK(ext_out, 4'h5)
        ext_out_req <= 4'h8;
        repeat (4) @(posedge clock);
        `CHK(ext_out, 4'hd)
        output_off <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK(ext_out, 4'h0)
        apb(0, CBC_ADDR_STATUS, 0);
        `CHK(rd[7:4], 4'h0)
        output_off <= 1'b0;
        ext_out_req <= 4'h0;
        apb(1, CBC_ADDR_FORCE, 0);
        $display("test force done");
    endtask : t_force
    // pin pulses long enough for stages 2 and 3 to agree
    task pin_pulse(input logic [3:0] c, input logic [3:0] x, input int n);
        repeat (n) begin
            count_in <= c;
            index_in <= x;
            repeat (3) @(posedge clock);
            count_in <= 4'h0;
            index_in <= 4'h0;
            repeat (3) @(posedge clock);
        end
    endtask : pin_pulse
    task t_count;
        apb(1, CBC_ADDR_MODE, 0);
        apb(1, CBC_ADDR_CTRL, 0);
        repeat (WT) @(posedge clock);
        pin_pulse(4'h3, 4'h0, 3);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h3)
        apb(1, CBC_ADDR_CTRL, 32'h0000_2000);
        repeat (WT) @(posedge clock);
        pin_pulse(4'h3, 4'h0, 2);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h5)
        apb(0, CBC_ADDR_COUNT0 + 12'h004, 0);
        `CHK(rd, 32'h3)
        apb(1, CBC_ADDR_CTRL, 32'h0000_2001);
        repeat (WT) @(posedge clock);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h0)
        apb(0, CBC_ADDR_COUNT0 + 12'h004, 0);
        `CHK(rd, 32'h3)
        apb(1, CBC_ADDR_MODE, 32'h0000_0001);
        apb(1, CBC_ADDR_CTRL, 0);
        repeat (WT) @(posedge clock);
        pin_pulse(4'h1, 4'h0, 2);
        pin_pulse(4'h0, 4'h1, 1);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h2)
        apb(1, CBC_ADDR_CTRL, 32'h0000_0001);
        repeat (WT) @(posedge clock);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h2)
        pin_pulse(4'h0, 4'h1, 1);
        apb(0, CBC_ADDR_COUNT0, 0);
        `CHK(rd, 32'h0)
        $display("test count done");
    endtask : t_count
    // ********************************************
    // run control
    // ********************************************
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        end_sim;
    end
    initial begin
        n_mismatch = 0; tests_run = 0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; output_off = 1'b0;
        count_in = 4'h0; index_in = 4'h0; ext_out_req = 4'h0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_regs;
        t_cmp;
        t_force;
        t_count;
        end_sim;
    end
endmodule : testbench
bind cbc_top cbc_chk u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_in(count_in), .index_in(index_in), .ext_out_req(ext_out_req),
    .output_off(output_off), .ext_out(ext_out), .comparing(comparing));
